// ===== rtl/pesr_defs.svh
// Constants for the program and erase suspend and resume controller
`ifndef PESR_DEFS_SVH
`define PESR_DEFS_SVH

// ************************************************************
// Widths and address fields
// ************************************************************
`define PESR_ADDR_W 24
`define PESR_SECTOR_LSB 16
`define PESR_PAGE_LSB 8
`define PESR_NEST_MAX 2

// ************************************************************
// Status and flag status bit positions
// ************************************************************
`define PESR_SR_BUSY_BIT 0
`define PESR_FSR_READY_BIT 7
`define PESR_FSR_SUSPEND_BIT 2

// ************************************************************
// Timing
// ************************************************************
`define PESR_CLK_MHZ 10
`define PESR_LAT_PROG_US 7
`define PESR_LAT_ERASE_US 15
`define PESR_LAT_PROG_CYC (`PESR_LAT_PROG_US * `PESR_CLK_MHZ)
`define PESR_LAT_ERASE_CYC (`PESR_LAT_ERASE_US * `PESR_CLK_MHZ)
`define PESR_LAT_W 8

`endif

// ===== rtl/pesr_pkg.sv
// Types shared by the suspend and resume controller
`include "pesr_defs.svh"

package pesr_pkg;

   // ************************************************************
   // Decoded instruction classes
   // ************************************************************
   typedef enum logic [3:0] {
      CMD_READ,
      CMD_STATUS_READ,
      CMD_PAGE_PROGRAM,
      CMD_SECTOR_ERASE,
      CMD_SMALL_BLOCK_ERASE,
      CMD_WHOLE_ARRAY_ERASE,
      CMD_NONVOLATILE_CONFIG_WRITE,
      CMD_ONE_TIME_AREA_PROGRAM,
      CMD_STATUS_WRITE,
      CMD_DEEP_POWER_DOWN,
      CMD_SUSPEND_INSTRUCTION,
      CMD_RESUME,
      CMD_OTHER
   } pesr_cmd_e;

   // Kind of the running or suspended operation
   typedef enum logic [1:0] {
      KIND_PROGRAM,
      KIND_SECTOR_ERASE,
      KIND_SMALL_ERASE,
      KIND_FIXED
   } pesr_kind_e;

   // Operating state
   typedef enum logic [1:0] {
      ST_STANDBY,
      ST_BUSY,
      ST_SUSPENDING,
      ST_SUSPENDED
   } pesr_state_e;

   typedef struct packed {
      pesr_cmd_e op;
      logic [`PESR_ADDR_W-1:0] addr;
   } pesr_cmd_s;

   typedef struct packed {
      pesr_kind_e kind;
      logic [`PESR_ADDR_W-1:0] addr;
   } pesr_entry_s;

   // Link side state
   typedef struct packed {
      pesr_cmd_s hold;
      logic req_tgl;
      logic ready;
   } pesr_link_s;

   // Core side state
   typedef struct packed {
      pesr_state_e state;
      pesr_entry_s cur;
      pesr_entry_s [`PESR_NEST_MAX-1:0] stack;
      logic [1:0] depth;
      logic [`PESR_LAT_W-1:0] lat_cnt;
      logic pend_valid;
      logic [`PESR_ADDR_W-1:0] pend_addr;
      logic req_seen;
      logic busy;
      logic ready;
      logic susp;
      logic accept;
      logic reject;
      logic undef;
      logic start;
      logic pause;
      logic resume;
   } pesr_core_s;

endpackage : pesr_pkg

// ===== rtl/pesr_sync.sv
// Two flip-flop synchroniser for a level
`timescale 1ns/10ps

module pesr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } pesr_sync_s;

   pesr_sync_s s_reg;
   pesr_sync_s s_next;

   // The first stage feeds only the second stage
   always_comb
   begin
      s_next.meta = i_async;
      s_next.sync = s_reg.meta;
   end

   // Register both stages
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign o_sync = s_reg.sync;

endmodule : pesr_sync

// ===== rtl/pesr_core.sv
// Program and erase suspend and resume controller with serial link front end
//
// Contract
// - Suspend sector, small block erase and programs.
// - Whole erase, config write, OTP never suspend.
// - Suspend sets flag status bit 2 immediately.
// - After latency busy clears, ready sets.
// - Program, small erase latency: reads only.
// - Sector erase latency: most instructions accepted.
// - Reset and resume clear suspended state.
// - Sector erase suspended: no erase, program elsewhere.
// - Small erase suspended: no modify; reads and other instructions accepted.
// - Program suspended: no modify; reads and other instructions accepted.
// - Reads of suspended region flagged undefined data.
// - One nesting level: program inside sector erase suspend.
// - Resume newest suspended first, then older.
// - Exactly one operating state at once.
// - Only resume instruction continues suspended work.
// - Resume outside suspended state is ignored.
// - Resume sets busy, clears ready until done.
// - Status reads accepted in every state.
`timescale 1ns/10ps
`include "pesr_defs.svh"

module pesr_core
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   input wire logic i_sclk,
   input wire logic i_cmd_valid,
   input pesr_pkg::pesr_cmd_s i_cmd,
   input wire logic i_op_done,
   output logic o_link_ready,
   output logic [7:0] o_status,
   output logic [7:0] o_flag_status,
   output pesr_pkg::pesr_state_e o_state,
   output logic o_cmd_accept,
   output logic o_cmd_reject,
   output logic o_read_undefined,
   output logic o_op_start,
   output logic o_op_pause,
   output logic o_op_resume,
   output pesr_pkg::pesr_entry_s o_op
);
   import pesr_pkg::*;

   localparam logic [`PESR_LAT_W-1:0] LAT_PROG = `PESR_LAT_W'(`PESR_LAT_PROG_CYC);
   localparam logic [`PESR_LAT_W-1:0] LAT_ERASE = `PESR_LAT_W'(`PESR_LAT_ERASE_CYC);
   localparam int SEC_W = `PESR_ADDR_W - `PESR_SECTOR_LSB;
   localparam int PAGE_W = `PESR_ADDR_W - `PESR_PAGE_LSB;

   pesr_link_s l_reg;
   pesr_link_s l_next;
   pesr_core_s c_reg;
   pesr_core_s c_next;
   logic ack_sync;
   logic req_sync;

   // ************************************************************
   // Link domain: hold one instruction until the core has taken it
   // ************************************************************

   // Returning acknowledge toggle into the link clock
   pesr_sync #(.WIDTH(1)) u_ack_sync (
      .i_clk(i_sclk),
      .i_reset_n(i_reset_n),
      .i_async(c_reg.req_seen),
      .o_sync(ack_sync)
   );

   // New instructions are dropped while the previous one is still crossing
   always_comb
   begin
      l_next = l_reg;
      if (i_cmd_valid && l_reg.ready)
      begin
         l_next.hold = i_cmd;
         l_next.req_tgl = ~l_reg.req_tgl;
      end
      l_next.ready = (ack_sync == l_next.req_tgl);
   end

   always_ff @(posedge i_sclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         l_reg <= '{hold: '{op: CMD_OTHER, addr: '0}, req_tgl: 1'b0, ready: 1'b1};
      end
      else
      begin
         l_reg <= l_next;
      end
   end

   assign o_link_ready = l_reg.ready;

   // ************************************************************
   // Core domain: suspend, resume and acceptance control
   // ************************************************************

   // Request toggle into the core clock; held word is stable once it flips
   pesr_sync #(.WIDTH(1)) u_req_sync (
      .i_clk(i_mclk),
      .i_reset_n(i_reset_n),
      .i_async(l_reg.req_tgl),
      .o_sync(req_sync)
   );

   // Does an address fall in the region of a suspended operation
   function automatic logic hits(input pesr_entry_s e, input logic [`PESR_ADDR_W-1:0] a);
      logic same_sec;
      logic same_page;
      same_sec = (e.addr[`PESR_ADDR_W-1 -: SEC_W] == a[`PESR_ADDR_W-1 -: SEC_W]);
      same_page = (e.addr[`PESR_ADDR_W-1 -: PAGE_W] == a[`PESR_ADDR_W-1 -: PAGE_W]);
      hits = (e.kind == KIND_PROGRAM) ? same_page : same_sec;
   endfunction : hits

   // Map a modify instruction onto an operation kind
   function automatic pesr_kind_e kind_of(input pesr_cmd_e op);
      unique case (op)
         CMD_PAGE_PROGRAM: kind_of = KIND_PROGRAM;
         CMD_SECTOR_ERASE: kind_of = KIND_SECTOR_ERASE;
         CMD_SMALL_BLOCK_ERASE: kind_of = KIND_SMALL_ERASE;
         default: kind_of = KIND_FIXED;
      endcase
   endfunction : kind_of

   // Next state of the core
   always_comb
   begin
      pesr_cmd_s c;
      pesr_entry_s top;
      logic new_cmd;
      logic modify;
      logic region_hit;
      logic [1:0] idx;
      c = l_reg.hold;
      idx = 2'(c_reg.depth - 2'd1);
      top = c_reg.stack[idx[0]];
      new_cmd = (req_sync != c_reg.req_seen);
      modify = (c.op == CMD_PAGE_PROGRAM) || (c.op == CMD_SECTOR_ERASE) ||
               (c.op == CMD_SMALL_BLOCK_ERASE) || (c.op == CMD_WHOLE_ARRAY_ERASE) ||
               (c.op == CMD_NONVOLATILE_CONFIG_WRITE) ||
               (c.op == CMD_ONE_TIME_AREA_PROGRAM) || (c.op == CMD_STATUS_WRITE);
      region_hit = 1'b0;
      for (int i = 0; i < `PESR_NEST_MAX; i++)
      begin
         if (i < int'(c_reg.depth) && hits(c_reg.stack[i], c.addr))
         begin
            region_hit = 1'b1;
         end
      end

      c_next = c_reg;
      c_next.accept = 1'b0;
      c_next.reject = 1'b0;
      c_next.undef = 1'b0;
      c_next.start = 1'b0;
      c_next.pause = 1'b0;
      c_next.resume = 1'b0;

      // Latency runs down while reads are still being taken
      if (c_reg.state == ST_SUSPENDING)
      begin
         c_next.lat_cnt = c_reg.lat_cnt - `PESR_LAT_W'(1);
      end
      // Internal events first; a waiting instruction is taken next cycle
      if (c_reg.state == ST_SUSPENDING && c_reg.lat_cnt == `PESR_LAT_W'(1))
      begin
         c_next.state = ST_SUSPENDED;
         c_next.busy = 1'b0;
         c_next.ready = 1'b1;
         if (c_reg.pend_valid)
         begin
            // Program taken during sector erase latency starts now
            c_next.state = ST_BUSY;
            c_next.cur = '{kind: KIND_PROGRAM, addr: c_reg.pend_addr};
            c_next.start = 1'b1;
            c_next.busy = 1'b1;
            c_next.ready = 1'b0;
            c_next.pend_valid = 1'b0;
         end
      end
      else if (c_reg.state == ST_BUSY && i_op_done)
      begin
         // A nested program falls back to the suspended erase below it
         c_next.state = (c_reg.depth == 2'd0) ? ST_STANDBY : ST_SUSPENDED;
         c_next.busy = 1'b0;
         c_next.ready = 1'b1;
      end
      else if (new_cmd)
      begin
         c_next.req_seen = req_sync;
         unique case (c_reg.state)
            ST_STANDBY:
            begin
               // Suspend and resume have nothing to act on here
               if (c.op != CMD_SUSPEND_INSTRUCTION && c.op != CMD_RESUME)
               begin
                  c_next.accept = 1'b1;
                  if (modify)
                  begin
                     c_next.state = ST_BUSY;
                     c_next.cur = '{kind: kind_of(c.op), addr: c.addr};
                     c_next.start = 1'b1;
                     c_next.busy = 1'b1;
                     c_next.ready = 1'b0;
                  end
               end
            end
            ST_BUSY:
            begin
               if (c.op == CMD_STATUS_READ)
               begin
                  c_next.accept = 1'b1;
               end
               else if (c.op == CMD_SUSPEND_INSTRUCTION)
               begin
                  if (c_reg.cur.kind != KIND_FIXED && c_reg.depth < 2'(`PESR_NEST_MAX))
                  begin
                     c_next.accept = 1'b1;
                     c_next.stack[c_reg.depth[0]] = c_reg.cur;
                     c_next.depth = 2'(c_reg.depth + 2'd1);
                     c_next.state = ST_SUSPENDING;
                     c_next.susp = 1'b1;
                     c_next.pause = 1'b1;
                     c_next.lat_cnt = (c_reg.cur.kind == KIND_PROGRAM) ? LAT_PROG : LAT_ERASE;
                  end
                  else
                  begin
                     c_next.reject = 1'b1;
                  end
               end
               else if (c.op != CMD_RESUME)
               begin
                  c_next.reject = 1'b1;
               end
            end
            ST_SUSPENDING:
            begin
               if (c.op == CMD_READ || c.op == CMD_STATUS_READ)
               begin
                  c_next.accept = 1'b1;
                  c_next.undef = (c.op == CMD_READ) && region_hit;
               end
               else if (c.op == CMD_SUSPEND_INSTRUCTION || c.op == CMD_RESUME)
               begin
                  // Not yet suspended, so nothing to resume or suspend again
                  c_next.undef = 1'b0;
               end
               else if (top.kind != KIND_SECTOR_ERASE)
               begin
                  c_next.reject = 1'b1;
               end
               else if (c.op == CMD_PAGE_PROGRAM)
               begin
                  if (!c_reg.pend_valid && !hits(top, c.addr))
                  begin
                     c_next.accept = 1'b1;
                     c_next.pend_valid = 1'b1;
                     c_next.pend_addr = c.addr;
                  end
                  else
                  begin
                     c_next.reject = 1'b1;
                  end
               end
               else if (modify || c.op == CMD_DEEP_POWER_DOWN)
               begin
                  c_next.reject = 1'b1;
               end
               else
               begin
                  c_next.accept = 1'b1;
               end
            end
            ST_SUSPENDED:
            begin
               if (c.op == CMD_RESUME)
               begin
                  // Newest entry continues first; the older waits below
                  c_next.accept = 1'b1;
                  c_next.state = ST_BUSY;
                  c_next.cur = top;
                  c_next.depth = idx;
                  c_next.susp = (idx != 2'd0);
                  c_next.resume = 1'b1;
                  c_next.busy = 1'b1;
                  c_next.ready = 1'b0;
               end
               else if (c.op == CMD_READ || c.op == CMD_STATUS_READ)
               begin
                  c_next.accept = 1'b1;
                  c_next.undef = (c.op == CMD_READ) && region_hit;
               end
               else if (c.op == CMD_PAGE_PROGRAM)
               begin
                  if (top.kind == KIND_SECTOR_ERASE && !hits(top, c.addr))
                  begin
                     c_next.accept = 1'b1;
                     c_next.state = ST_BUSY;
                     c_next.cur = '{kind: KIND_PROGRAM, addr: c.addr};
                     c_next.start = 1'b1;
                     c_next.busy = 1'b1;
                     c_next.ready = 1'b0;
                  end
                  else
                  begin
                     c_next.reject = 1'b1;
                  end
               end
               else if (modify)
               begin
                  c_next.reject = 1'b1;
               end
               else if (c.op != CMD_SUSPEND_INSTRUCTION)
               begin
                  c_next.accept = 1'b1;
               end
            end
         endcase
      end
   end

   // Power loss is reset: nothing stays suspended across it
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         c_reg <= '0;
         c_reg.state <= ST_STANDBY;
         c_reg.ready <= 1'b1;
      end
      else if (i_clk_en)
      begin
         c_reg <= c_next;
      end
   end

   // ************************************************************
   // Outputs, all straight from core flip-flops
   // ************************************************************
   always_comb
   begin
      o_status = '0;
      o_status[`PESR_SR_BUSY_BIT] = c_reg.busy;
      o_flag_status = '0;
      o_flag_status[`PESR_FSR_READY_BIT] = c_reg.ready;
      o_flag_status[`PESR_FSR_SUSPEND_BIT] = c_reg.susp;
   end

   assign o_state = c_reg.state;
   assign o_cmd_accept = c_reg.accept;
   assign o_cmd_reject = c_reg.reject;
   assign o_read_undefined = c_reg.undef;
   assign o_op_start = c_reg.start;
   assign o_op_pause = c_reg.pause;
   assign o_op_resume = c_reg.resume;
   assign o_op = c_reg.cur;

endmodule : pesr_core

// ===== sim/pesr_core_checker.sv
// Port assertions for the suspend and resume controller
`timescale 1ns/10ps
// ********
// Checker
// ********
module pesr_core_checker
(
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   input wire logic i_sclk,
   input wire logic i_cmd_valid,
   input pesr_pkg::pesr_cmd_s i_cmd,
   input wire logic i_op_done,
   input wire logic o_link_ready,
   input wire logic [7:0] o_status,
   input wire logic [7:0] o_flag_status,
   input pesr_pkg::pesr_state_e o_state,
   input wire logic o_cmd_accept,
   input wire logic o_cmd_reject,
   input wire logic o_read_undefined,
   input wire logic o_op_start,
   input wire logic o_op_pause,
   input wire logic o_op_resume,
   input pesr_pkg::pesr_entry_s o_op
);
   import pesr_pkg::*;
   // All checks live in the core clock domain
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_reset_n);

   a_pause_flag: assert property (
      o_op_pause |-> o_op.kind != KIND_FIXED && o_flag_status[2] && o_state == ST_SUSPENDING)
      else $error("pause without suspend flag or on a fixed operation");
   a_prog_latency: assert property (
      o_op_pause && o_op.kind == KIND_PROGRAM |-> ##69 o_state == ST_SUSPENDING
      ##1 (o_state == ST_SUSPENDED && !o_status[0] && o_flag_status[7]))
      else $error("program suspend latency wrong");
   a_erase_latency: assert property (
      o_op_pause && o_op.kind != KIND_PROGRAM |-> ##149 o_state == ST_SUSPENDING
      ##1 o_state != ST_SUSPENDING)
      else $error("erase suspend latency wrong");
   a_suspended_flags: assert property (
      o_state == ST_SUSPENDED |-> !o_status[0] && o_flag_status[7] && o_flag_status[2])
      else $error("suspended flags wrong");
   a_busy_flags: assert property (
      (o_state == ST_BUSY || o_state == ST_SUSPENDING) |-> o_status[0] && !o_flag_status[7])
      else $error("busy flags wrong");
   a_resume_busy: assert property (
      o_op_resume |-> o_state == ST_BUSY && o_status[0] && !o_flag_status[7])
      else $error("resume did not raise busy");
   a_no_self_go: assert property (
      o_state == ST_SUSPENDED ##1 o_state == ST_BUSY |-> o_op_resume || o_op_start)
      else $error("suspended work continued on its own");
   a_standby_clear: assert property (
      o_state == ST_STANDBY |-> o_status == 8'h00 && o_flag_status == 8'h80)
      else $error("standby flags wrong");
   a_done_ends: assert property (
      i_op_done && i_clk_en && o_state == ST_BUSY |=> o_state != ST_BUSY)
      else $error("busy held after completion");
   a_undef_read: assert property (
      o_read_undefined |-> o_cmd_accept && o_flag_status[2])
      else $error("undefined data flag outside an accepted read");
   a_one_answer: assert property (
      !(o_cmd_accept && o_cmd_reject))
      else $error("accept and reject together");
endmodule : pesr_core_checker

bind pesr_core pesr_core_checker i_pesr_core_checker (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
   .i_clk_en(i_clk_en), .i_sclk(i_sclk), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
   .i_op_done(i_op_done), .o_link_ready(o_link_ready), .o_status(o_status),
   .o_flag_status(o_flag_status), .o_state(o_state), .o_cmd_accept(o_cmd_accept),
   .o_cmd_reject(o_cmd_reject), .o_read_undefined(o_read_undefined),
   .o_op_start(o_op_start), .o_op_pause(o_op_pause), .o_op_resume(o_op_resume), .o_op(o_op));

// ===== sim/pesr_host.sv
// Host controller model on the serial link
`timescale 1ns/10ps
// ********
// Host
// ********
module pesr_host
(
   output logic o_sclk,
   output logic o_cmd_valid,
   output pesr_pkg::pesr_cmd_s o_cmd,
   input wire logic i_link_ready
);
   import pesr_pkg::*;
   initial
   begin
      o_sclk = 1'b0;
      o_cmd_valid = 1'b0;
      o_cmd = '0;
   end
   // One link period; the clock stands still between frames
   task automatic tick();
      #16 o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
   endtask : tick
   // Sends one instruction; ok drops if the link never frees up
   task automatic send(input pesr_cmd_e op, input logic [23:0] addr, output logic ok);
      int n;
      n = 0;
      #7;
      tick();
      while (i_link_ready !== 1'b1 && n < 40)
      begin
         tick();
         n++;
      end
      o_cmd_valid = 1'b1;
      o_cmd = '{op: op, addr: addr};
      tick();
      // Released lines show the inverse of the old command, not the command itself
      o_cmd_valid = 1'b0;
      o_cmd = ~o_cmd;
      n = 0;
      tick();
      while (i_link_ready !== 1'b1 && n < 40)
      begin
         tick();
         n++;
      end
      tick();
      ok = (n < 40);
   endtask : send
endmodule : pesr_host

// ===== sim/pesr_core_test.sv
// Self-checking bench for the suspend and resume controller
`timescale 1ns/10ps
// ********
// Bench
// ********
module pesr_core_test;
   import pesr_pkg::*;
   logic i_mclk, i_reset_n, i_sclk, i_cmd_valid, i_op_done, o_link_ready, i_clk_en;
   logic o_cmd_accept, o_cmd_reject, o_read_undefined, o_op_start, o_op_pause, o_op_resume;
   logic [7:0] o_status;
   logic [7:0] o_flag_status;
   pesr_cmd_s i_cmd;
   pesr_state_e o_state;
   pesr_entry_s o_op;
   int err_count = 0;
   int checked = 0;
   int n_acc = 0;
   int n_rej = 0;
   int n_und = 0;

   pesr_core i_pesr_core (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
      .i_sclk(i_sclk), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_op_done(i_op_done),
      .o_link_ready(o_link_ready), .o_status(o_status), .o_flag_status(o_flag_status),
      .o_state(o_state), .o_cmd_accept(o_cmd_accept), .o_cmd_reject(o_cmd_reject),
      .o_read_undefined(o_read_undefined), .o_op_start(o_op_start), .o_op_pause(o_op_pause),
      .o_op_resume(o_op_resume), .o_op(o_op));
   pesr_host i_pesr_host (.o_sclk(i_sclk), .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd),
      .i_link_ready(o_link_ready));

   // Core clock, 100 ns
   initial
   begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end
   // Answer pulses last one cycle, so they are tallied as they come
   always @(negedge i_mclk)
   begin
      if (o_cmd_accept === 1'b1) n_acc++;
      if (o_cmd_reject === 1'b1) n_rej++;
      if (o_read_undefined === 1'b1) n_und++;
   end

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp)
      begin
         $display("[ERR] %0t %s", $time, msg);
         err_count++;
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask : idle
   task automatic flags(input pesr_state_e st, input logic [7:0] sr, input logic [7:0] fsr);
      chk({30'h0, o_state}, {30'h0, st}, "state");
      chk({24'h0, o_status}, {24'h0, sr}, "status");
      chk({24'h0, o_flag_status}, {24'h0, fsr}, "flag status");
   endtask : flags
   // Sends one instruction and checks how many answers of each kind came back
   task automatic issue(input pesr_cmd_e op, input logic [23:0] addr, input int acc,
      input int rej, input int und);
      int a;
      int r;
      int u;
      logic ok;
      a = n_acc;
      r = n_rej;
      u = n_und;
      i_pesr_host.send(op, addr, ok);
      if (ok !== 1'b1)
      begin
         chk(32'h0, 32'h1, "link never freed");
         close_out();
      end
      idle(3);
      chk(n_acc - a, acc, "accept count");
      chk(n_rej - r, rej, "reject count");
      chk(n_und - u, und, "undefined read count");
   endtask : issue
   task automatic wait_state(input pesr_state_e st, input int bound);
      int n;
      n = 0;
      while (o_state !== st && n < bound)
      begin
         idle(1);
         n++;
      end
      if (o_state !== st)
      begin
         chk(32'h0, 32'h1, "state wait ran out");
         close_out();
      end
   endtask : wait_state
   task automatic finish_op();
      @(posedge i_mclk);
      i_op_done <= 1'b1;
      @(posedge i_mclk);
      i_op_done <= 1'b0;
      idle(2);
   endtask : finish_op

   // ********
   // Scenarios
   // ********
   task automatic sc_idle();
      flags(ST_STANDBY, 8'h00, 8'h80);
      issue(CMD_SUSPEND_INSTRUCTION, 24'h0, 0, 0, 0);
      issue(CMD_RESUME, 24'h0, 0, 0, 0);
      flags(ST_STANDBY, 8'h00, 8'h80);
   endtask : sc_idle
   // Erase suspended, program nested and suspended, then both resumed
   task automatic sc_nested();
      issue(CMD_SECTOR_ERASE, 24'h010000, 1, 0, 0);
      flags(ST_BUSY, 8'h01, 8'h00);
      issue(CMD_STATUS_READ, 24'h0, 1, 0, 0);
      idle(400);
      issue(CMD_SUSPEND_INSTRUCTION, 24'h0, 1, 0, 0);
      flags(ST_SUSPENDING, 8'h01, 8'h04);
      issue(CMD_READ, 24'h030000, 1, 0, 0);
      issue(CMD_DEEP_POWER_DOWN, 24'h0, 0, 1, 0);
      wait_state(ST_SUSPENDED, 200);
      flags(ST_SUSPENDED, 8'h00, 8'h84);
      issue(CMD_SMALL_BLOCK_ERASE, 24'h030000, 0, 1, 0);
      issue(CMD_READ, 24'h010100, 1, 0, 1);
      issue(CMD_PAGE_PROGRAM, 24'h010200, 0, 1, 0);
      issue(CMD_PAGE_PROGRAM, 24'h020000, 1, 0, 0);
      flags(ST_BUSY, 8'h01, 8'h04);
      idle(400);
      issue(CMD_SUSPEND_INSTRUCTION, 24'h0, 1, 0, 0);
      wait_state(ST_SUSPENDED, 100);
      issue(CMD_PAGE_PROGRAM, 24'h040000, 0, 1, 0);
      issue(CMD_SUSPEND_INSTRUCTION, 24'h0, 0, 0, 0);
      issue(CMD_READ, 24'h020000, 1, 0, 1);
      issue(CMD_READ, 24'h020100, 1, 0, 0);
      idle(300);
      flags(ST_SUSPENDED, 8'h00, 8'h84);
      issue(CMD_RESUME, 24'h0, 1, 0, 0);
      chk({6'h0, o_op}, {6'h0, KIND_PROGRAM, 24'h020000}, "newest resumed first");
      flags(ST_BUSY, 8'h01, 8'h04);
      finish_op();
      flags(ST_SUSPENDED, 8'h00, 8'h84);
      issue(CMD_RESUME, 24'h0, 1, 0, 0);
      chk({6'h0, o_op}, {6'h0, KIND_SECTOR_ERASE, 24'h010000}, "older resumed");
      flags(ST_BUSY, 8'h01, 8'h00);
      finish_op();
      flags(ST_STANDBY, 8'h00, 8'h80);
   endtask : sc_nested
   // Program given during sector erase latency starts when the latency ends
   task automatic sc_queued();
      issue(CMD_SECTOR_ERASE, 24'h010000, 1, 0, 0);
      idle(400);
      issue(CMD_SUSPEND_INSTRUCTION, 24'h0, 1, 0, 0);
      issue(CMD_PAGE_PROGRAM, 24'h020000, 1, 0, 0);
      wait_state(ST_BUSY, 200);
      chk({6'h0, o_op}, {6'h0, KIND_PROGRAM, 24'h020000}, "queued program");
      flags(ST_BUSY, 8'h01, 8'h04);
      finish_op();
      flags(ST_SUSPENDED, 8'h00, 8'h84);
      issue(CMD_RESUME, 24'h0, 1, 0, 0);
      finish_op();
      flags(ST_STANDBY, 8'h00, 8'h80);
   endtask : sc_queued
   // Operations that must run to completion
   task automatic sc_fixed();
      pesr_cmd_e ops[3] = '{CMD_WHOLE_ARRAY_ERASE, CMD_NONVOLATILE_CONFIG_WRITE,
         CMD_ONE_TIME_AREA_PROGRAM};
      foreach (ops[k])
      begin
         issue(ops[k], 24'h0, 1, 0, 0);
         issue(CMD_SUSPEND_INSTRUCTION, 24'h0, 0, 1, 0);
         // A completion seen while the enable is low must not move the core
         @(posedge i_mclk);
         i_clk_en <= 1'b0;
         finish_op();
         flags(ST_BUSY, 8'h01, 8'h00);
         @(posedge i_mclk);
         i_clk_en <= 1'b1;
         finish_op();
         flags(ST_STANDBY, 8'h00, 8'h80);
      end
   endtask : sc_fixed
   // Small block erase suspended, then power lost mid-suspend
   task automatic sc_small();
      issue(CMD_SMALL_BLOCK_ERASE, 24'h005000, 1, 0, 0);
      idle(400);
      issue(CMD_SUSPEND_INSTRUCTION, 24'h0, 1, 0, 0);
      issue(CMD_PAGE_PROGRAM, 24'h050000, 0, 1, 0);
      issue(CMD_READ, 24'h050000, 1, 0, 0);
      wait_state(ST_SUSPENDED, 200);
      issue(CMD_SECTOR_ERASE, 24'h050000, 0, 1, 0);
      issue(CMD_PAGE_PROGRAM, 24'h050000, 0, 1, 0);
      issue(CMD_READ, 24'h000100, 1, 0, 1);
      issue(CMD_READ, 24'h050000, 1, 0, 0);
      @(posedge i_mclk);
      i_reset_n <= 1'b0;
      idle(4);
      i_reset_n <= 1'b1;
      idle(2);
      flags(ST_STANDBY, 8'h00, 8'h80);
      issue(CMD_RESUME, 24'h0, 0, 0, 0);
   endtask : sc_small

   // Reset, then the scenarios in turn
   initial
   begin
      i_reset_n = 1'b0;
      i_op_done = 1'b0;
      i_clk_en = 1'b1;
      repeat (4) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      idle(2);
      sc_idle();
      sc_nested();
      sc_queued();
      sc_fixed();
      sc_small();
      close_out();
   end
endmodule : pesr_core_test
